//--- xo32_osc_ctrl.sv
// 32 kHz crystal oscillator control: run gating, start-up timing, outputs, pad mode
// assumes an ahb-lite master on clk_sys; reference and crystal clocks arrive as pins
// Functional notes
// [RQ1] on-demand set: oscillator runs only while some peripheral requests it
// [RQ2] on-demand clear: oscillator runs continuously while enabled, requests ignored
// [RQ3] on-demand gating keeps working in standby just as in active mode
// [RQ4] start-up code 4/5/6 selects 65536/131072/262144 reference cycles; 7 reserved
// [RQ5] start-up counts reference cycles then three crystal cycles before ready
// [RQ6] 1 kHz output driven only while its enable is set
// [RQ7] 32 kHz output driven only while its enable is set
// [RQ8] crystal mode clear: external clock in, out pad released; set: crystal
// [RQ9] enable clear stops oscillator; set lets it run, subject to on-demand
// [RQ10] standby run with on-demand decides whether oscillator runs in standby
// [RQ11] disabled oscillator ignores requests; start-up count restarts on each start
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module xo32_osc_ctrl
    import xo32_pkg::*;
#(
    parameter logic [18:0] P_CNT_2S = 19'd65536,
    parameter logic [18:0] P_CNT_4S = 19'd131072,
    parameter logic [18:0] P_CNT_8S = 19'd262144
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // peripheral clock requests and sleep state
    input  wire logic [XO32_NREQ-1:0]  clk_req,
    input  wire logic                  standby,
    // oscillator clocks, both asynchronous pins
    input  wire logic                  ulp_reference_osc,
    input  wire logic                  crystal_32k_osc,
    // oscillator and pad control
    output logic                       osc_run,
    output logic                       osc_ready,
    output logic                       crystal_in_pad_xtal,
    output logic                       crystal_out_pad_xtal,
    output logic                       crystal_out_pad_release,
    // clock outputs
    output logic                       clk_32khz_out,
    output logic                       clk_1khz_out,
    output logic                       out_32khz_active,
    output logic                       out_1khz_active
);
    // control register fields
    logic [31:0]            ctrl_reg;
    logic                   osc_enable;
    logic                   crystal_mode_select;
    logic                   out_32khz_enable;
    logic                   out_1khz_enable;
    logic                   standby_run;
    logic                   on_demand_gate;
    logic [2:0]             startup_sel;

    // bus data-phase capture
    logic                   wr_pend_reg;
    logic                   rd_pend_reg;
    logic [7:0]             addr_reg;
    logic                   addr_ok;

    // run gating
    logic                   req_any;
    logic                   run_next;
    logic                   osc_run_reg;

    // synchronisers and edge strobes
    logic [1:0]             ulp_sync_reg;
    logic                   ulp_last_reg;
    logic [1:0]             xo_sync_reg;
    logic                   xo_last_reg;
    logic                   ulp_edge;
    logic                   xo_edge;

    // start-up timer
    logic [XO32_CNT_W-1:0]  su_limit;
    logic                   timer_ready;

    // clock outputs
    logic [3:0]             div_cnt_reg;
    logic                   clk_1k_raw_reg;
    logic                   clk_32k_reg;
    logic                   clk_1k_reg;

    function automatic logic [XO32_CNT_W-1:0] su_count(input logic [2:0] code);
        logic [XO32_CNT_W-1:0] cnt;
        cnt = XO32_CNT_MIN;
        case (code)
            XO32_SU_2S: cnt = P_CNT_2S;
            XO32_SU_4S: cnt = P_CNT_4S;
            // reserved code keeps the longest delay rather than a short one
            default:    cnt = (code >= XO32_SU_8S) ? P_CNT_8S : XO32_CNT_MIN;
        endcase
        return cnt;
    endfunction : su_count

    function automatic logic reg_hit(input logic [7:0] a);
        return (a == XO32_OFS_CTRL) || (a == XO32_OFS_STATUS);
    endfunction : reg_hit

    assign osc_enable          = ctrl_reg[XO32_B_ENABLE];
    assign crystal_mode_select = ctrl_reg[XO32_B_XTAL];
    assign out_32khz_enable    = ctrl_reg[XO32_B_OUT_32KHZ_ENABLE];
    assign out_1khz_enable     = ctrl_reg[XO32_B_OUT_1KHZ_ENABLE];
    assign standby_run         = ctrl_reg[XO32_B_STBY];
    assign on_demand_gate      = ctrl_reg[XO32_B_ONDEM];
    assign startup_sel         = ctrl_reg[XO32_B_SU_HI:XO32_B_SU_LO];

    // bus: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = reg_hit(addr_reg);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && (htrans == XO32_HTRANS_NSEQ) && hwrite
                           && (hsize == XO32_HSIZE_WORD);
            rd_pend_reg <= hsel && (htrans == XO32_HTRANS_NSEQ) && !hwrite;
            addr_reg    <= haddr[7:0];
        end
    end

    // writes to unmapped or read-only words are dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= XO32_CTRL_RST;
        end else if (wr_pend_reg && addr_reg == XO32_OFS_CTRL) begin
            ctrl_reg <= hwdata & XO32_CTRL_MASK;
        end
    end

    // read data comes out of a register during the data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && (htrans == XO32_HTRANS_NSEQ) && !hwrite) begin
            case (haddr[7:0])
                XO32_OFS_CTRL:   hrdata <= ctrl_reg;
                XO32_OFS_STATUS: begin
                    hrdata                <= 32'h0000_0000;
                    hrdata[XO32_B_READY]  <= timer_ready;
                    hrdata[XO32_B_RUN]    <= osc_run_reg;
                    hrdata[XO32_B_REQ]    <= req_any;
                end
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // run decision; standby without standby_run parks the oscillator
    assign req_any = |clk_req;

    always_comb begin
        run_next = 1'b0;
        if (osc_enable) begin                                      // [RQ9] [RQ11]
            if (on_demand_gate) begin
                run_next = req_any && (!standby || standby_run);   // [RQ1] [RQ3] [RQ10]
            end else begin
                run_next = !standby || standby_run;                // [RQ2] [RQ10]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_run_reg <= 1'b0;
        end else begin
            osc_run_reg <= run_next;
        end
    end

    assign osc_run = osc_run_reg;

    // pad wiring follows crystal mode, registered one clock later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            crystal_in_pad_xtal     <= 1'b0;
            crystal_out_pad_xtal    <= 1'b0;
            crystal_out_pad_release <= 1'b1;
        end else begin
            crystal_in_pad_xtal     <= crystal_mode_select;        // [RQ8]
            crystal_out_pad_xtal    <= crystal_mode_select;        // [RQ8]
            crystal_out_pad_release <= !crystal_mode_select;       // [RQ8]
        end
    end

    // two flip-flops before any logic reads the oscillator pins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ulp_sync_reg <= 2'b00;
            ulp_last_reg <= 1'b0;
        end else begin
            ulp_sync_reg <= {ulp_sync_reg[0], ulp_reference_osc};
            ulp_last_reg <= ulp_sync_reg[1];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xo_sync_reg <= 2'b00;
            xo_last_reg <= 1'b0;
        end else begin
            xo_sync_reg <= {xo_sync_reg[0], crystal_32k_osc};
            xo_last_reg <= xo_sync_reg[1];
        end
    end

    assign ulp_edge = ulp_sync_reg[1] && !ulp_last_reg;
    assign xo_edge  = xo_sync_reg[1] && !xo_last_reg;
    assign su_limit = su_count(startup_sel);                       // [RQ4]

    xo32_startup_timer u_timer (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .run      (osc_run_reg),
        .limit    (su_limit),
        .ulp_edge (ulp_edge),
        .xo_edge  (xo_edge),
        .ready    (timer_ready)
    );

    assign osc_ready = timer_ready;

    // 1 kHz divider counts crystal edges only once the oscillator is ready
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt_reg    <= 4'h0;
            clk_1k_raw_reg <= 1'b0;
        end else if (!timer_ready) begin
            div_cnt_reg    <= 4'h0;
            clk_1k_raw_reg <= 1'b0;
        end else if (xo_edge) begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
            if (div_cnt_reg == XO32_DIV_LAST) begin
                clk_1k_raw_reg <= !clk_1k_raw_reg;
            end
        end
    end

    // the 32 kHz copy is a resampled image, good for timing, not for edge-accurate use
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_32k_reg <= 1'b0;
            clk_1k_reg  <= 1'b0;
        end else begin
            clk_32k_reg <= xo_sync_reg[1] && timer_ready && out_32khz_enable; // [RQ7]
            clk_1k_reg  <= clk_1k_raw_reg && timer_ready && out_1khz_enable;  // [RQ6]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_32khz_active <= 1'b0;
            out_1khz_active  <= 1'b0;
        end else begin
            out_32khz_active <= out_32khz_enable && timer_ready;  // [RQ7]
            out_1khz_active  <= out_1khz_enable && timer_ready;   // [RQ6]
        end
    end

    assign clk_32khz_out = clk_32k_reg;
    assign clk_1khz_out  = clk_1k_reg;

    // checks
    sequence s_idle_demand;
        osc_enable && on_demand_gate && !req_any;
    endsequence

    sequence s_free_run;
        osc_enable && !on_demand_gate && !standby;
    endsequence

    a_demand_idle_off: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
        s_idle_demand |=> !osc_run)
        else $error("oscillator runs with no request under on-demand");

    a_demand_req_on: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
        osc_enable && on_demand_gate && req_any && !standby |=> osc_run)
        else $error("requested oscillator did not start");

    a_free_run_on: assert property (@(posedge clk_sys) disable iff (rst) // [RQ2]
        s_free_run ##1 s_free_run |-> osc_run)
        else $error("enabled oscillator not running without on-demand");

    a_standby_demand: assert property (@(posedge clk_sys) disable iff (rst) // [RQ3]
        s_idle_demand and (standby && standby_run) |=> !osc_run)
        else $error("on-demand gating lost in standby");

    a_standby_park: assert property (@(posedge clk_sys) disable iff (rst) // [RQ10]
        standby && !standby_run |=> !osc_run)
        else $error("oscillator runs in standby without standby run");

    a_disable_stops: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
        !osc_enable |=> !osc_run ##1 !osc_ready)
        else $error("oscillator not stopped by disable");

    a_startup_code: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
        startup_sel == XO32_SU_4S |-> su_limit == P_CNT_4S)
        else $error("start-up code maps to the wrong count");

    a_ready_restart: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
        $fell(osc_run) |=> !osc_ready [*2])
        else $error("ready survived an oscillator stop");

    a_out32_gate: assert property (@(posedge clk_sys) disable iff (rst) // [RQ7]
        !out_32khz_enable |=> !clk_32khz_out && !out_32khz_active)
        else $error("32 kHz output driven while disabled");

    a_out1k_gate: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
        !out_1khz_enable |=> !clk_1khz_out && !out_1khz_active)
        else $error("1 kHz output driven while disabled");

    a_pad_mode: assert property (@(posedge clk_sys) disable iff (rst) // [RQ8]
        $changed(crystal_mode_select) |=> crystal_out_pad_release == !crystal_mode_select
            && crystal_in_pad_xtal == crystal_mode_select)
        else $error("pad wiring does not follow crystal mode");
endmodule : xo32_osc_ctrl

//--- xo32_startup_timer.sv
// shared constants for the 32 kHz crystal oscillator control, and its start-up timer
// assumes the ulp and crystal edge strobes are already synchronised one-cycle pulses
package xo32_pkg;
    // register byte offsets
    localparam logic [7:0]  XO32_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  XO32_OFS_STATUS  = 8'h04;
    // control field positions
    localparam int          XO32_B_ENABLE    = 1;
    localparam int          XO32_B_XTAL      = 2;
    localparam int          XO32_B_OUT_32KHZ_ENABLE     = 3;
    localparam int          XO32_B_OUT_1KHZ_ENABLE      = 4;
    localparam int          XO32_B_STBY      = 6;
    localparam int          XO32_B_ONDEM     = 7;
    localparam int          XO32_B_SU_LO     = 8;
    localparam int          XO32_B_SU_HI     = 10;
    // status field positions
    localparam int          XO32_B_READY     = 0;
    localparam int          XO32_B_RUN       = 1;
    localparam int          XO32_B_REQ       = 2;
    // control reset value: everything off, start-up code 0x0
    localparam logic [31:0] XO32_CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] XO32_CTRL_MASK   = 32'h0000_07DE;
    // start-up codes and reference-oscillator counts
    localparam logic [2:0]  XO32_SU_2S       = 3'h4;
    localparam logic [2:0]  XO32_SU_4S       = 3'h5;
    localparam logic [2:0]  XO32_SU_8S       = 3'h6;
    localparam int          XO32_CNT_W       = 19;
    localparam logic [18:0] XO32_CNT_MIN     = 19'h0_0001;
    localparam logic [1:0]  XO32_XO_CYCLES   = 2'h3;
    // 1 kHz output: toggle every 16 crystal edges, 32 edges a period
    localparam logic [3:0]  XO32_DIV_LAST    = 4'hF;
    localparam int          XO32_NREQ        = 8;
    localparam logic [1:0]  XO32_HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  XO32_HSIZE_WORD  = 3'h2;
endpackage : xo32_pkg

`timescale 1ns/1ps

module xo32_startup_timer
    import xo32_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // control
    input  wire logic                  run,
    input  wire logic [XO32_CNT_W-1:0] limit,
    input  wire logic                  ulp_edge,
    input  wire logic                  xo_edge,
    // status
    output logic                       ready
);
    typedef enum logic [1:0] {XO32_T_IDLE, XO32_T_ULP, XO32_T_XO, XO32_T_DONE} xo32_tstate_e;

    xo32_tstate_e            state_reg;
    logic [XO32_CNT_W-1:0]   ulp_cnt_reg;
    logic [1:0]              xo_cnt_reg;

    // dropping run returns to idle so every start counts from zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg   <= XO32_T_IDLE;
            ulp_cnt_reg <= '0;
            xo_cnt_reg  <= '0;
        end else if (!run) begin
            state_reg   <= XO32_T_IDLE;                            // [RQ11]
            ulp_cnt_reg <= '0;
            xo_cnt_reg  <= '0;
        end else begin
            case (state_reg)
                XO32_T_IDLE: begin
                    state_reg <= XO32_T_ULP;
                end
                XO32_T_ULP: begin
                    if (ulp_edge) begin
                        ulp_cnt_reg <= ulp_cnt_reg + 1'b1;         // [RQ5]
                        if (ulp_cnt_reg + 1'b1 >= limit) begin
                            state_reg <= XO32_T_XO;
                        end
                    end
                end
                XO32_T_XO: begin
                    if (xo_edge) begin
                        xo_cnt_reg <= xo_cnt_reg + 1'b1;           // [RQ5]
                        if (xo_cnt_reg + 1'b1 == XO32_XO_CYCLES) begin
                            state_reg <= XO32_T_DONE;
                        end
                    end
                end
                XO32_T_DONE: begin
                    state_reg <= XO32_T_DONE;
                end
                default: begin
                    state_reg <= XO32_T_IDLE;
                end
            endcase
        end
    end

    assign ready = (state_reg == XO32_T_DONE);

    a_xo_tail_cycles: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
        $rose(ready) |-> $past(xo_edge) && $past(xo_cnt_reg) == 2'h2)
        else $error("ready rose without the third crystal edge");
endmodule : xo32_startup_timer

//--- xo32_partner.sv
// far-side model: free-running reference osc, a crystal, eight clock requesters
// assumes the bench steers the requester levels and that clk_sys rising edges sit off pin edges
`timescale 1ns/1ps

module xo32_partner (
    // system side
    input  wire logic       clk_sys,
    input  wire logic       osc_run,
    input  wire logic [7:0] req_level,
    // pins toward the block
    output logic [7:0]      clk_req,
    output logic            ulp_reference_osc,
    output logic            crystal_32k_osc
);
    initial begin
        clk_req = 8'h00;
        ulp_reference_osc = 1'b0;
        crystal_32k_osc = 1'b0;
    end

    // reference runs free, its edges landing on clk_sys falling edges
    always #80 ulp_reference_osc = ~ulp_reference_osc;

    // a stopped crystal does not swing, so ready cannot be earned while stopped
    always #75 if (osc_run === 1'b1) crystal_32k_osc = ~crystal_32k_osc;

    always @(posedge clk_sys) clk_req <= req_level;
endmodule : xo32_partner

//--- crystal_32k_osc_control_tb_top.sv
// bench for the 32 kHz crystal oscillator control, registers reached over ahb-lite
// assumes xo32_partner on the far side; start-up counts shrunk to 4/8/16
`timescale 1ns/1ps

module crystal_32k_osc_control_tb_top;
    import xo32_pkg::*;
    localparam logic [31:0] EN = 32'h1 << XO32_B_ENABLE;
    localparam logic [31:0] XT = 32'h1 << XO32_B_XTAL;
    localparam logic [31:0] K32 = 32'h1 << XO32_B_OUT_32KHZ_ENABLE;
    localparam logic [31:0] K1 = 32'h1 << XO32_B_OUT_1KHZ_ENABLE;
    localparam logic [31:0] SB = 32'h1 << XO32_B_STBY;
    localparam logic [31:0] OD = 32'h1 << XO32_B_ONDEM;
    localparam logic [31:0] A_C = {24'h0, XO32_OFS_CTRL};
    localparam logic [31:0] A_S = {24'h0, XO32_OFS_STATUS};
    logic        clk_sys, rst, hsel, hwrite, standby, ulp, xo;
    logic        osc_run, osc_ready, in_x, out_x, out_rel, k32, k1, k32_on, k1_on;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  req_level, clk_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic        hreadyout, hresp;
    wire         hready = hreadyout;
    int          n_mismatch, tests_run;

    xo32_osc_ctrl #(.P_CNT_2S(19'h0_0004), .P_CNT_4S(19'h0_0008),
                    .P_CNT_8S(19'h0_0010)) i_xo32_osc_ctrl (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_req(clk_req),
        .standby(standby), .ulp_reference_osc(ulp), .crystal_32k_osc(xo),
        .osc_run(osc_run), .osc_ready(osc_ready), .crystal_in_pad_xtal(in_x),
        .crystal_out_pad_xtal(out_x), .crystal_out_pad_release(out_rel),
        .clk_32khz_out(k32), .clk_1khz_out(k1), .out_32khz_active(k32_on),
        .out_1khz_active(k1_on));

    xo32_partner i_xo32_partner (.clk_sys(clk_sys), .osc_run(osc_run),
        .req_level(req_level), .clk_req(clk_req), .ulp_reference_osc(ulp),
        .crystal_32k_osc(xo));

    always #2.5 clk_sys = ~clk_sys;

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    // one clock with a bound, so a hang ends in the closing report
    task automatic step(inout int i);
        @(posedge clk_sys);
        i++;
        if (i > 4000) begin
            chk("wait bound", 32'h0, 32'h1);
            complete_run;
        end
    endtask : step

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        input logic [2:0] sz, output logic [31:0] q);
        int i;
        i = 0;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= XO32_HTRANS_NSEQ;
        hwrite <= wr;
        hsize <= sz;
        do step(i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do step(i); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, XO32_HSIZE_WORD, q);
    endtask : wr

    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, XO32_HSIZE_WORD, q);
        chk(what, q, e);
    endtask : rdchk

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic t_regs;
        logic [31:0] q;
        rdchk("ctrl reset", A_C, XO32_CTRL_RST);
        rdchk("status reset", A_S, 32'h0);
        chk("bus resp", {hresp, hreadyout, out_rel, in_x, out_x}, 32'h0000_000C);
        wr(A_C, 32'hFFFF_FFFF);
        rdchk("ctrl mask", A_C, XO32_CTRL_MASK);
        wr(A_C, 32'h0);
        xfer(1'b1, A_C, 32'h0000_0002, 3'h0, q);
        wr(32'h0000_0008, 32'hFFFF_FFFF);
        wr(A_S, 32'hFFFF_FFFF);
        rdchk("byte write", A_C, 32'h0);
        rdchk("unmapped", 32'h0000_0008, 32'h0);
        rdchk("status ro", A_S, 32'h0);
    endtask : t_regs

    task automatic run_case(input logic [31:0] c, input logic [7:0] r, input logic s,
                            input logic e);
        wr(A_C, c);
        @(posedge clk_sys);
        req_level <= r;
        standby <= s;
        settle;
        chk("osc_run", 32'(osc_run), 32'(e));
    endtask : run_case

    task automatic t_gating;
        int i;
        i = 0;
        run_case(EN, 8'h00, 1'b0, 1'b1);
        run_case(EN, 8'hFF, 1'b0, 1'b1);
        run_case(EN | OD, 8'h00, 1'b0, 1'b0);
        for (int k = 0; k < XO32_NREQ; k++) begin
            run_case(EN | OD, 8'h01 << k, 1'b0, 1'b1);
        end
        // a requester stays up, so start-up must finish and all status bits stand
        while (osc_ready !== 1'b1) step(i);
        rdchk("status run req", A_S, 32'h0000_0007);
        run_case(OD, 8'hFF, 1'b0, 1'b0);
        run_case(32'h0, 8'h00, 1'b0, 1'b0);
        run_case(EN, 8'h00, 1'b1, 1'b0);
        run_case(EN | SB, 8'h00, 1'b1, 1'b1);
        run_case(EN | SB | OD, 8'h00, 1'b1, 1'b0);
        run_case(EN | SB | OD, 8'h10, 1'b1, 1'b1);
        run_case(32'h0, 8'h00, 1'b0, 1'b0);
    endtask : t_gating

    // restart mid-count, then count pin edges until ready
    task automatic t_startup(input logic [2:0] code, input int n);
        int i, rc, xc;
        logic rp, xp;
        logic [31:0] c;
        c = EN | (32'(code) << XO32_B_SU_LO);
        wr(A_C, c);
        repeat (100) @(posedge clk_sys);
        wr(A_C, 32'h0);
        settle;
        chk("ready drop", 32'(osc_ready), 32'h0);
        wr(A_C, c);
        i = 0;
        rc = 0;
        xc = 0;
        rp = ulp;
        xp = xo;
        while (osc_ready !== 1'b1) begin
            step(i);
            if (rc < n) rc += int'(ulp && !rp);
            else xc += int'(xo && !xp);
            rp = ulp;
            xp = xo;
        end
        chk("ref cycles", 32'(rc), 32'(n));
        chk("xo cycles ok", 32'(xc >= 3 && xc <= 4), 32'h1);
        wr(A_C, 32'h0);
    endtask : t_startup

    task automatic t_outputs;
        int i, xc, kc;
        logic xp, kp, sp, seen;
        i = 0;
        wr(A_C, EN | K32 | K1 | (32'(XO32_SU_2S) << XO32_B_SU_LO));
        while (osc_ready !== 1'b1) step(i);
        settle;
        chk("out active", {k32_on, k1_on}, 32'h3);
        while (k1 !== 1'b0) step(i);
        while (k1 !== 1'b1) step(i);
        xc = 0;
        kc = 0;
        xp = xo;
        sp = k32;
        kp = 1'b1;
        while (!(k1 && !kp)) begin
            kp = k1;
            step(i);
            xc += int'(xo && !xp);
            kc += int'(k32 && !sp);
            xp = xo;
            sp = k32;
        end
        chk("1k period", 32'(xc), 32'h20);
        chk("32k edges", 32'(kc >= xc - 1 && kc <= xc + 1), 32'h1);
        wr(A_C, EN | (32'(XO32_SU_2S) << XO32_B_SU_LO));
        settle;
        seen = 1'b0;
        repeat (200) begin
            @(posedge clk_sys);
            seen = seen | k1 | k32 | k1_on | k32_on;
        end
        chk("outputs off", 32'(seen), 32'h0);
        wr(A_C, 32'h0);
    endtask : t_outputs

    task automatic t_pads;
        wr(A_C, XT);
        settle;
        chk("pads crystal", {in_x, out_x, out_rel}, 32'h6);
        wr(A_C, 32'h0);
        settle;
        chk("pads external", {in_x, out_x, out_rel}, 32'h1);
    endtask : t_pads

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {hsel, hwrite, standby} = 3'h0;
        htrans = 2'h0;
        hsize = XO32_HSIZE_WORD;
        haddr = 32'h0;
        hwdata = 32'h0;
        req_level = 8'h00;
        n_mismatch = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_gating();
        t_startup(XO32_SU_2S, 4);
        t_startup(XO32_SU_4S, 8);
        t_startup(XO32_SU_8S, 16);
        t_startup(3'h7, 16);
        t_outputs();
        t_pads();
        complete_run();
    end
endmodule : crystal_32k_osc_control_tb_top
